// >>> design/lps_pkg.sv
// constants and types for the load program sequencer
//
// Operation
// - twelve programs of ten step slots each
// - step names setup slot 1 to 120; code accepts any 7-bit slot value, 0 to 127, unchecked
// - steps run in ascending order from one
// - step loads all active channels together
// - run mode: skip, auto or manual
// - on-time 0.1 to 60.0 seconds; code accepts any 10-bit count of 0.1 s ticks, 0 to 1023, unchecked
// - optional off-time always follows on-time
// - optional short starts with on-time
// - optional pass/fail delay within total time
// - limit check runs without delay window
// - short channel off ignores short time
// - save commits current program to working store
// - program defaults clear working store only
// - chain start selects any program
// - successor off ends chain, loops allowed
// - chain follows links, any order
// - chain defaults: start one, successors off
// - per-channel active flags, default cleared
// - refuse start with no active channel
// - manual step waits for next command
// - stop aborts run immediately
package lps_pkg;
  localparam int          PROGS         = 12;
  localparam int          STEPS         = 10;
  localparam int          TOTAL         = 120;
  // register byte addresses
  localparam logic [7:0]  A_CTRL        = 8'h00;
  localparam logic [7:0]  A_CONFIG      = 8'h04;
  localparam logic [7:0]  A_CHAIN_START = 8'h08;
  localparam logic [7:0]  A_EDIT_SEL    = 8'h0c;
  localparam logic [7:0]  A_STEP_A      = 8'h10;
  localparam logic [7:0]  A_STEP_B      = 8'h14;
  localparam logic [7:0]  A_STEP_C      = 8'h18;
  localparam logic [7:0]  A_STATUS      = 8'h1c;
  localparam logic [7:0]  A_SUCC_BASE   = 8'h20;
  localparam logic [7:0]  A_SUCC_END    = 8'h50;
  // control command bits
  localparam int          C_START       = 0;
  localparam int          C_NEXT        = 1;
  localparam int          C_STOP        = 2;
  localparam int          C_SAVE        = 3;
  localparam int          C_PDEF        = 4;
  localparam int          C_CDEF        = 5;
  localparam int          C_LOAD        = 6;
  // field positions
  localparam int          CF_LIMIT      = 8;
  localparam int          CF_PROG_LSB   = 12;
  localparam int          SA_MODE_LSB   = 8;
  localparam int          SA_SHCH_LSB   = 16;
  localparam int          S_HI_LSB      = 16;
  localparam int          ST_PROG_LSB   = 8;
  localparam int          ST_STEP_LSB   = 12;
  // reset values and range limits
  localparam logic [6:0]  DEF_SLOT      = 7'h01;
  localparam logic [9:0]  DEF_ON        = 10'h001;
  localparam logic [3:0]  DEF_START     = 4'h1;
  localparam logic [3:0]  LAST_PROG     = 4'hc;
  localparam logic [3:0]  STEP_END      = 4'ha;
  // timing
  localparam int          CLK_PERIOD_NS = 20;
  localparam int          TICK_NS       = 100_000_000;
  localparam int          TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    LPS_SKIP   = 2'h0,
    LPS_AUTO   = 2'h1,
    LPS_MANUAL = 2'h2
  } lps_run_type;

  typedef enum logic [4:0] {
    LPS_IDLE = 5'h01,
    LPS_STEP = 5'h02,
    LPS_WAIT = 5'h04,
    LPS_ON   = 5'h08,
    LPS_OFF  = 5'h10
  } lps_state_type;
endpackage : lps_pkg

// >>> design/lps_sequencer.sv
// program sequencer for a multi-channel electronic load
`timescale 1ns/1ps
module lps_sequencer
  import lps_pkg::*;
#(
  parameter int TICK_CYCLES_P = TICK_CYCLES
)
(
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        we_i,
  input  wire logic        re_i,
  output logic      [31:0] rdata_o,
  input  wire logic [7:0]  limit_fail_i,
  output logic      [7:0]  load_on_o,
  output logic      [7:0]  short_o,
  output logic      [6:0]  setup_slot_o,
  output logic             apply_o,
  output logic             eval_window_o,
  output logic             busy_o,
  output logic             done_o,
  output logic             pass_o,
  output logic             fail_o
);

  // flat index of a step in the working store
  function automatic logic [6:0] step_idx(input logic [3:0] p,
                                          input logic [3:0] s);
    step_idx = 7'(7'(p) * 7'd10 + 7'(s));
  endfunction : step_idx

  // working store, all twelve programs
  logic [6:0]    w_slot [TOTAL];
  logic [1:0]    w_mode [TOTAL];
  logic [9:0]    w_on   [TOTAL];
  logic [9:0]    w_off  [TOTAL];
  logic [9:0]    w_sht  [TOTAL];
  logic [9:0]    w_pf   [TOTAL];
  logic [3:0]    w_shch [TOTAL];
  // edit buffer, one program
  logic [6:0]    b_slot [STEPS];
  logic [1:0]    b_mode [STEPS];
  logic [9:0]    b_on   [STEPS];
  logic [9:0]    b_off  [STEPS];
  logic [9:0]    b_sht  [STEPS];
  logic [9:0]    b_pf   [STEPS];
  logic [3:0]    b_shch [STEPS];
  logic [3:0]    succ   [PROGS];
  logic [3:0]    chain_start;
  logic [7:0]    cfg_active;
  logic          cfg_limit;
  logic [3:0]    edit_prog;
  logic [3:0]    edit_sel;
  lps_state_type state;
  logic [3:0]    cur_prog;
  logic [3:0]    cur_step;
  logic [10:0]   elapsed;
  logic [22:0]   tick_cnt;
  logic          refused;
  logic          finished;
  logic          fail_acc;

  // command strobes from the control register
  logic ctrl_wr;
  logic cmd_start;
  logic cmd_next;
  logic cmd_stop;
  logic cmd_save;
  logic cmd_pdef;
  logic cmd_cdef;
  logic cmd_load;
  assign ctrl_wr   = we_i && (addr_i == A_CTRL);
  assign cmd_start = ctrl_wr && wdata_i[C_START];
  assign cmd_next  = ctrl_wr && wdata_i[C_NEXT];
  assign cmd_stop  = ctrl_wr && wdata_i[C_STOP];
  assign cmd_save  = ctrl_wr && wdata_i[C_SAVE];
  assign cmd_pdef  = ctrl_wr && wdata_i[C_PDEF];
  assign cmd_cdef  = ctrl_wr && wdata_i[C_CDEF];
  assign cmd_load  = ctrl_wr && wdata_i[C_LOAD];

  // fields of the step being run; step ten reads slot zero, unused
  logic [6:0]  cidx;
  logic [1:0]  c_mode;
  logic [9:0]  c_on;
  logic [9:0]  c_off;
  logic [9:0]  c_sht;
  logic [9:0]  c_pf;
  logic [3:0]  c_shch;
  logic [10:0] next_elapsed;
  logic        tick;
  logic        end_on;
  logic        end_off;
  logic        start_step;
  logic        chain_end;
  logic        window;
  logic        running;
  logic        edit_ok;
  assign cidx   = step_idx(cur_prog, (cur_step == STEP_END) ? 4'h0
                                                            : cur_step);
  assign c_mode = w_mode[cidx];
  assign c_on   = w_on[cidx];
  assign c_off  = w_off[cidx];
  assign c_sht  = w_sht[cidx];
  assign c_pf   = w_pf[cidx];
  assign c_shch = w_shch[cidx];
  assign next_elapsed = elapsed + 11'h001;
  assign tick    = (tick_cnt == 23'(TICK_CYCLES_P - 1));
  assign end_on  = tick && (next_elapsed == {1'b0, c_on});
  assign end_off = tick && (next_elapsed == ({1'b0, c_on} + {1'b0, c_off}));
  assign running = (state == LPS_ON) || (state == LPS_OFF);
  // manual steps only start on next, auto steps at once
  assign start_step = !cmd_stop &&
    (((state == LPS_STEP) && (cur_step != STEP_END) &&
      (c_mode == LPS_AUTO)) ||
     ((state == LPS_WAIT) && cmd_next));
  assign chain_end = !cmd_stop && (state == LPS_STEP) &&
                     (cur_step == STEP_END) && (succ[cur_prog] == 4'h0);
  // no delay set means the whole step is evaluated
  assign window = running && ((c_pf == 10'h000) ||
                              (elapsed >= {1'b0, c_pf}));
  assign edit_ok = (edit_sel < STEP_END);

  // configuration and chain registers
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      cfg_active  <= 8'h00;
      cfg_limit   <= 1'b0;
      edit_prog   <= 4'h0;
      edit_sel    <= 4'h0;
      chain_start <= DEF_START;
      for (int i = 0; i < PROGS; i++)
        succ[i] <= 4'h0;
    end
    else if (cmd_cdef)
    begin
      chain_start <= DEF_START;
      for (int i = 0; i < PROGS; i++)
        succ[i] <= 4'h0;
    end
    else if (we_i)
    begin
      if (addr_i == A_CONFIG)
      begin
        cfg_active <= wdata_i[7:0];
        cfg_limit  <= wdata_i[CF_LIMIT];
        if (wdata_i[CF_PROG_LSB+:4] < LAST_PROG)
          edit_prog <= wdata_i[CF_PROG_LSB+:4];
      end
      else if (addr_i == A_CHAIN_START)
      begin
        if ((wdata_i[3:0] != 4'h0) && (wdata_i[3:0] <= LAST_PROG))
          chain_start <= wdata_i[3:0];
      end
      else if (addr_i == A_EDIT_SEL)
        edit_sel <= wdata_i[3:0];
      else if ((addr_i >= A_SUCC_BASE) && (addr_i < A_SUCC_END) &&
               (addr_i[1:0] == 2'h0))
      begin
        if (wdata_i[3:0] <= LAST_PROG)
          succ[4'(addr_i[7:2] - A_SUCC_BASE[7:2])] <= wdata_i[3:0];
      end
    end
  end

  // edit buffer: register writes and reload from the working store
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      for (int i = 0; i < STEPS; i++)
      begin
        b_slot[i] <= DEF_SLOT;
        b_mode[i] <= LPS_SKIP;
        b_on[i]   <= DEF_ON;
        b_off[i]  <= 10'h000;
        b_sht[i]  <= 10'h000;
        b_pf[i]   <= 10'h000;
        b_shch[i] <= 4'h0;
      end
    end
    else if (cmd_load)
    begin
      for (int i = 0; i < STEPS; i++)
      begin
        b_slot[i] <= w_slot[step_idx(edit_prog, 4'(i))];
        b_mode[i] <= w_mode[step_idx(edit_prog, 4'(i))];
        b_on[i]   <= w_on[step_idx(edit_prog, 4'(i))];
        b_off[i]  <= w_off[step_idx(edit_prog, 4'(i))];
        b_sht[i]  <= w_sht[step_idx(edit_prog, 4'(i))];
        b_pf[i]   <= w_pf[step_idx(edit_prog, 4'(i))];
        b_shch[i] <= w_shch[step_idx(edit_prog, 4'(i))];
      end
    end
    else if (we_i && edit_ok)
    begin
      if (addr_i == A_STEP_A)
      begin
        b_slot[edit_sel] <= wdata_i[6:0];
        b_mode[edit_sel] <= wdata_i[SA_MODE_LSB+:2];
        b_shch[edit_sel] <= wdata_i[SA_SHCH_LSB+:4];
      end
      else if (addr_i == A_STEP_B)
      begin
        b_on[edit_sel]  <= wdata_i[9:0];
        b_off[edit_sel] <= wdata_i[S_HI_LSB+:10];
      end
      else if (addr_i == A_STEP_C)
      begin
        b_sht[edit_sel] <= wdata_i[9:0];
        b_pf[edit_sel]  <= wdata_i[S_HI_LSB+:10];
      end
    end
  end

  // working store: save from buffer, or back to defaults
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      for (int i = 0; i < TOTAL; i++)
      begin
        w_slot[i] <= DEF_SLOT;
        w_mode[i] <= LPS_SKIP;
        w_on[i]   <= DEF_ON;
        w_off[i]  <= 10'h000;
        w_sht[i]  <= 10'h000;
        w_pf[i]   <= 10'h000;
        w_shch[i] <= 4'h0;
      end
    end
    // defaults are a synchronous command, kept off the async reset path
    else if (cmd_pdef)
    begin
      for (int i = 0; i < TOTAL; i++)
      begin
        w_slot[i] <= DEF_SLOT;
        w_mode[i] <= LPS_SKIP;
        w_on[i]   <= DEF_ON;
        w_off[i]  <= 10'h000;
        w_sht[i]  <= 10'h000;
        w_pf[i]   <= 10'h000;
        w_shch[i] <= 4'h0;
      end
    end
    else if (cmd_save)
    begin
      for (int i = 0; i < STEPS; i++)
      begin
        w_slot[step_idx(edit_prog, 4'(i))] <= b_slot[i];
        w_mode[step_idx(edit_prog, 4'(i))] <= b_mode[i];
        w_on[step_idx(edit_prog, 4'(i))]   <= b_on[i];
        w_off[step_idx(edit_prog, 4'(i))]  <= b_off[i];
        w_sht[step_idx(edit_prog, 4'(i))]  <= b_sht[i];
        w_pf[step_idx(edit_prog, 4'(i))]   <= b_pf[i];
        w_shch[step_idx(edit_prog, 4'(i))] <= b_shch[i];
      end
    end
  end

  // tick divider restarts with each step so durations are exact
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      tick_cnt <= 23'h000000;
    else if (start_step || tick)
      tick_cnt <= 23'h000000;
    else
      tick_cnt <= tick_cnt + 23'h000001;
  end

  // run sequencer
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state    <= LPS_IDLE;
      cur_prog <= 4'h0;
      cur_step <= 4'h0;
      elapsed  <= 11'h000;
    end
    else if (cmd_stop)
      state <= LPS_IDLE;
    else if (start_step)
    begin
      state   <= LPS_ON;
      elapsed <= 11'h000;
    end
    else
    begin
      case (state)
        LPS_IDLE:
          if (cmd_start && (cfg_active != 8'h00))
          begin
            state    <= LPS_STEP;
            cur_prog <= chain_start - 4'h1;
            cur_step <= 4'h0;
          end
        LPS_STEP:
          if (cur_step == STEP_END)
          begin
            if (succ[cur_prog] == 4'h0)
              state <= LPS_IDLE;
            else
            begin
              cur_prog <= succ[cur_prog] - 4'h1;
              cur_step <= 4'h0;
            end
          end
          else if (c_mode == LPS_MANUAL)
            state <= LPS_WAIT;
          else
            cur_step <= cur_step + 4'h1;
        LPS_ON:
          if (end_on)
          begin
            elapsed <= next_elapsed;
            if (c_off != 10'h000)
              state <= LPS_OFF;
            else
            begin
              state    <= LPS_STEP;
              cur_step <= cur_step + 4'h1;
            end
          end
          else if (tick)
            elapsed <= next_elapsed;
        LPS_OFF:
          if (end_off)
          begin
            state    <= LPS_STEP;
            cur_step <= cur_step + 4'h1;
          end
          else if (tick)
            elapsed <= next_elapsed;
        default:
          state <= state;
      endcase
    end
  end

  // result flags, held until the next start
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      refused  <= 1'b0;
      finished <= 1'b0;
      fail_acc <= 1'b0;
    end
    else if (cmd_start && (state == LPS_IDLE))
    begin
      refused  <= (cfg_active == 8'h00);
      finished <= 1'b0;
      fail_acc <= 1'b0;
    end
    else
    begin
      if (chain_end)
        finished <= 1'b1;
      if (window && cfg_limit && |(limit_fail_i & cfg_active))
        fail_acc <= 1'b1;
    end
  end

  // channel outputs, all active channels switch together
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      load_on_o     <= 8'h00;
      short_o       <= 8'h00;
      setup_slot_o  <= DEF_SLOT;
      apply_o       <= 1'b0;
      eval_window_o <= 1'b0;
      busy_o        <= 1'b0;
      done_o        <= 1'b0;
      pass_o        <= 1'b0;
      fail_o        <= 1'b0;
    end
    else
    begin
      load_on_o <= (state == LPS_ON && !cmd_stop) ? cfg_active
                                                  : 8'h00;
      // short window starts with the on interval
      short_o <= (state == LPS_ON && !cmd_stop && c_shch != 4'h0 &&
                  elapsed < {1'b0, c_sht}) ?
                 8'(8'h01 << (c_shch - 4'h1)) : 8'h00;
      apply_o <= start_step;
      if (start_step)
        setup_slot_o <= w_slot[cidx];
      eval_window_o <= window && cfg_limit && !cmd_stop;
      busy_o  <= (state != LPS_IDLE) && !cmd_stop;
      done_o  <= chain_end;
      pass_o  <= (finished || chain_end) && cfg_limit && !fail_acc;
      fail_o  <= (finished || chain_end) && cfg_limit && fail_acc;
    end
  end

  // read data, one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      rdata_o <= 32'h00000000;
    else if (re_i)
    begin
      rdata_o <= 32'h00000000;
      if (addr_i == A_CONFIG)
        rdata_o <= {16'h0000, edit_prog, 3'h0, cfg_limit, cfg_active};
      else if (addr_i == A_CHAIN_START)
        rdata_o <= {28'h0000000, chain_start};
      else if (addr_i == A_EDIT_SEL)
        rdata_o <= {28'h0000000, edit_sel};
      else if (addr_i == A_STEP_A && edit_ok)
        rdata_o <= {12'h000, b_shch[edit_sel], 6'h00, b_mode[edit_sel],
                    1'b0, b_slot[edit_sel]};
      else if (addr_i == A_STEP_B && edit_ok)
        rdata_o <= {6'h00, b_off[edit_sel], 6'h00, b_on[edit_sel]};
      else if (addr_i == A_STEP_C && edit_ok)
        rdata_o <= {6'h00, b_pf[edit_sel], 6'h00, b_sht[edit_sel]};
      else if (addr_i == A_STATUS)
        rdata_o <= {16'h0000, cur_step, cur_prog, 2'h0, refused,
                    fail_o, pass_o, finished, (state == LPS_WAIT),
                    (state != LPS_IDLE)};
      else if ((addr_i >= A_SUCC_BASE) && (addr_i < A_SUCC_END) &&
               (addr_i[1:0] == 2'h0))
        rdata_o <= {28'h0000000,
                    succ[4'(addr_i[7:2] - A_SUCC_BASE[7:2])]};
    end
  end

  refuse_start_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (cmd_start && state == LPS_IDLE && cfg_active == 8'h00) |=>
      (state == LPS_IDLE && refused))
    else $error("start taken with no active channel");
  stop_abort_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (cmd_stop && running) |=> (state == LPS_IDLE && load_on_o == 8'h00))
    else $error("stop did not abort run");
  manual_hold_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (state == LPS_WAIT && !cmd_next && !cmd_stop) |=> state == LPS_WAIT)
    else $error("manual step left without next");
  skip_step_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (state == LPS_STEP && cur_step != STEP_END && c_mode == LPS_SKIP &&
     !cmd_stop) |=> (state == LPS_STEP && apply_o == 1'b0 &&
                     cur_step == $past(cur_step) + 4'h1))
    else $error("skipped step was not passed over");
  load_all_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (state == LPS_ON && !cmd_stop) |=> load_on_o == $past(cfg_active))
    else $error("load not applied to active channels");
  short_gate_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (short_o != 8'h00) |-> ($past(c_shch) != 4'h0 &&
                            $past(state) == LPS_ON))
    else $error("short asserted without short channel");
  chain_done_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    chain_end |=> (done_o && state == LPS_IDLE) ##1 !done_o)
    else $error("chain end without one done pulse");
  chain_def_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    cmd_cdef |=> (chain_start == DEF_START && succ[0] == 4'h0 &&
                  succ[PROGS-1] == 4'h0))
    else $error("chain defaults not restored");
  save_commit_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (cmd_save && !cmd_pdef) |=>
      (w_on[step_idx(edit_prog, 4'h0)] == $past(b_on[0]) &&
       w_mode[step_idx(edit_prog, 4'h9)] == $past(b_mode[9])))
    else $error("save did not commit edit buffer");
  off_follow_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (state == LPS_ON && end_on && c_off != 10'h000 && !cmd_stop) |=>
      (state == LPS_OFF) ##1 (load_on_o == 8'h00))
    else $error("off interval did not follow on");
endmodule : lps_sequencer

// >>> dv/lps_limit_model.sv
// limit comparator model standing beside the load outputs
`timescale 1ns/1ps
module lps_limit_model
(
  input  wire logic       clk_i,
  input  wire logic [7:0] fail_mask_i,
  input  wire logic [7:0] load_on_i,
  output logic      [7:0] limit_fail_o
);
  initial limit_fail_o = 8'h00;
  // a channel can only fail while its load draws current
  always @(posedge clk_i)
  begin
    limit_fail_o <= fail_mask_i & load_on_i;
  end
endmodule : lps_limit_model

// >>> dv/testbench.sv
// self-checking bench for the load program sequencer
`timescale 1ns/1ps
module testbench;
  import lps_pkg::*;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        we = 1'b0;
  logic        re = 1'b0;
  logic [7:0]  fail_mask = 8'h00;
  logic [31:0] rdata;
  logic [7:0]  limit_fail, load_on, short_channel_select;
  logic [6:0]  slot;
  logic        apply, eval_win, busy, done, pass, fail;
  logic [6:0]  slots[$];
  logic [7:0]  loads[$];
  logic [7:0]  short_seen;
  logic        done_seen;
  logic        eval_seen;
  logic        apply_d = 1'b0;
  logic [31:0] rv;
  int          n_mismatch = 0;
  int          cmp_count = 0;
  // register rows: address, write value, value read back
  logic [71:0] rows [0:7] = '{
    {8'h08, 32'h00000005, 32'h00000005},
    {8'h08, 32'h0000000d, 32'h00000005},
    {8'h08, 32'h00000000, 32'h00000005},
    {8'h20, 32'h00000002, 32'h00000002},
    {8'h2c, 32'h0000000d, 32'h00000000},
    {8'h0c, 32'h00000009, 32'h00000009},
    {8'h60, 32'hffffffff, 32'h00000000},
    {8'h14, 32'h02580258, 32'h02580258}};

  lps_sequencer #(.TICK_CYCLES_P(4)) u_lps_sequencer (
    .clk_i(clk), .reset_n_i(reset_n), .addr_i(addr), .wdata_i(wdata),
    .we_i(we), .re_i(re), .rdata_o(rdata), .limit_fail_i(limit_fail),
    .load_on_o(load_on), .short_o(short_channel_select), .setup_slot_o(slot),
    .apply_o(apply), .eval_window_o(eval_win), .busy_o(busy),
    .done_o(done), .pass_o(pass), .fail_o(fail));
  lps_limit_model u_lps_limit_model (
    .clk_i(clk), .fail_mask_i(fail_mask), .load_on_i(load_on),
    .limit_fail_o(limit_fail));

  initial
  begin
    forever #10 clk = ~clk;
  end
  // record every step start and what it drove
  always @(posedge clk)
  begin
    // loads switch one clock after the step start pulse
    if (apply_d === 1'b1)
      loads.push_back(load_on);
    if (apply === 1'b1)
      slots.push_back(slot);
    apply_d = apply;
    short_seen = short_seen | short_channel_select;
    eval_seen = eval_seen | eval_win;
    if (done === 1'b1)
      done_seen = 1'b1;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    we    <= 1'b1;
    @(posedge clk);
    we    <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    re   <= 1'b1;
    @(posedge clk);
    re   <= 1'b0;
    #1 d = rdata;
  endtask : rd
  task automatic set_step(input logic [3:0] s, input logic [31:0] a,
                          input logic [31:0] b, input logic [31:0] c);
    wr(A_EDIT_SEL, {28'h0, s});
    wr(A_STEP_A, a);
    wr(A_STEP_B, b);
    wr(A_STEP_C, c);
  endtask : set_step
  task automatic wait_done;
    for (int i = 0; i < 2000 && done_seen !== 1'b1; i++)
      @(posedge clk);
  endtask : wait_done
  // full chain: program 2, then program 1 with a manual third step
  task automatic run_chain(input logic [7:0] mask, input logic exp_fail);
    @(posedge clk);
    fail_mask <= mask;
    slots.delete();
    loads.delete();
    short_seen = 8'h00;
    eval_seen = 1'b0;
    done_seen = 1'b0;
    wr(A_CTRL, 32'h1);
    for (int i = 0; i < 300; i++)
    begin
      rd(A_STATUS, rv);
      if (rv[1] === 1'b1)
        break;
    end
    chk(32'(slots.size()), 32'd2);
    wr(A_CTRL, 32'h2);
    wait_done();
    chk({31'h0, done_seen}, 32'h1);
    chk({11'h0, slots[0], slots[1], slots[2]},
        {11'h0, 7'd20, 7'd7, 7'd9});
    chk({8'h0, loads[0], loads[1], loads[2]}, 32'h00050505);
    chk({24'h0, short_seen}, 32'h04);
    chk({31'h0, eval_seen}, 32'h1);
    chk({30'h0, pass, fail}, {30'h0, ~exp_fail, exp_fail});
  endtask : run_chain
  task automatic report_and_stop;
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : report_and_stop

  initial
  begin
    #1ms;
    n_mismatch++;
    report_and_stop();
  end
  initial
  begin
    repeat (4) @(posedge clk);
    #1 chk({busy, done, pass, fail, apply, eval_win, load_on, short_channel_select, slot},
           {6'h0, 8'h0, 8'h0, 7'h01});
    reset_n <= 1'b1;
    rd(A_CONFIG, rv);
    chk(rv, 32'h0);
    rd(A_CHAIN_START, rv);
    chk(rv, 32'h1);
    wr(A_CTRL, 32'h1);
    rd(A_STATUS, rv);
    chk({26'h0, rv[5], busy}, 32'h2);
    foreach (rows[i])
    begin
      wr(rows[i][71:64], rows[i][63:32]);
      rd(rows[i][71:64], rv);
      chk(rv, rows[i][31:0]);
    end
    // program 2 first: the save copies the whole edit buffer
    wr(A_CONFIG, 32'h00001105);
    set_step(4'h0, 32'h00000114, 32'h1, 32'h0);
    wr(A_CTRL, 32'h8);
    wr(A_CONFIG, 32'h00000105);
    set_step(4'h0, 32'h00030107, 32'h00010002, 32'h1);
    set_step(4'h2, 32'h00000209, 32'h1, 32'h0);
    wr(A_CTRL, 32'h8);
    wr(A_CHAIN_START, 32'h2);
    wr(8'h24, 32'h1);
    wr(8'h20, 32'h0);
    run_chain(8'h00, 1'b0);
    run_chain(8'h01, 1'b1);
    // stop in the middle of the first step
    done_seen = 1'b0;
    wr(A_CTRL, 32'h1);
    for (int i = 0; i < 50 && apply !== 1'b1; i++)
      @(posedge clk);
    wr(A_CTRL, 32'h4);
    repeat (2) @(posedge clk);
    #1 chk({24'h0, busy, done_seen, 6'h0} | {24'h0, load_on}, 32'h0);
    // program defaults leave every step skipped
    wr(A_CTRL, 32'h10);
    slots.delete();
    done_seen = 1'b0;
    wr(A_CTRL, 32'h1);
    wait_done();
    chk({31'h0, done_seen}, 32'h1);
    chk(32'(slots.size()), 32'd0);
    wr(A_CTRL, 32'h20);
    rd(A_CHAIN_START, rv);
    chk(rv, 32'h1);
    rd(8'h24, rv);
    chk(rv, 32'h0);
    report_and_stop();
  end
endmodule : testbench
